//--- logic/flash_buffer_host.sv
// What this block does
// R1: Buffer load uses 84h for the first buffer, 87h for the second.
// R2: Standard load address is 15 don't-care bits then 9 buffer index bits.
// R3: Binary load address is 16 don't-care bits then 8 buffer index bits.
// R4: Device stores data bytes consecutively and wraps to buffer location zero.
// R5: Buffer loading lasts until chip select rises.
// R6: Program with erase uses 83h for the first buffer, 86h for the second.
// R7: Standard program address is 15 page bits then 9 don't-care bits.
// R8: Binary program address is one don't-care bit, 15 page bits, 8 don't-care.
// R9: After auto-erase program, device erases the page to ones then programs it.
// R10: Device reports busy while the self-timed operation runs, within its maximum time.
// R11: Device verifies each byte and sets the error flag on any failure.
// R12: Program without erase uses 88h for the first buffer, 89h for the second.
// R13: No-erase program writes the buffer into the page without erasing first.
// R14: Host erases a page before issuing a no-erase program to it; this block does not erase, it refuses the order unless page_preerased is set.
// R15: Combined load and program uses 82h for first buffer, 85h for second.
// R16: Standard combined address is 15 page bits then 9 buffer index bits.
// R17: Binary combined address is one don't-care, 15 page, 8 buffer index bits.
// R18: Combined command loads with wraparound, then erases and programs on chip-select rise.
// R19: Device picks the address layout from its current page-size setting.
// R20: Opcode and address shift most significant bit first, sampled on rising clock.
`timescale 1ns/1ps
`default_nettype none
module flash_buffer_host
	import flash_host_pkg::*;
#(
	parameter logic [7:0] STATUS_OPCODE = 8'h00,
	parameter int READY_BIT = 7,
	parameter int ERROR_BIT = 5,
	parameter int ERASE_AND_PROGRAM_TIME_US = 50000,
	parameter int POLL_LIMIT_CYCLES = ERASE_AND_PROGRAM_TIME_US * CLK_MHZ
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire cmd_kind_e cmd_kind,
	input wire logic cmd_buffer,
	input wire logic binary_mode,
	input wire logic [PAGE_W-1:0] cmd_page,
	input wire logic [INDEX_STD_W-1:0] cmd_index,
	input wire logic page_preerased,
	output logic cmd_refused,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	input wire logic wr_last,
	output logic cmd_done,
	output logic flash_busy,
	output logic program_error,
	output logic timeout_error,
	output logic [7:0] status_byte,
	output logic spi_cs_n,
	output logic spi_sck,
	output logic spi_mosi,
	input wire logic spi_miso
);

	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_OPC = 7'b0000010,
		S_ADDR = 7'b0000100,
		S_DATA = 7'b0001000,
		S_STAT_OP = 7'b0010000,
		S_STAT_RD = 7'b0100000,
		S_CLOSE = 7'b1000000
	} state_e;

	state_e state;
	cmd_kind_e kind_q;
	logic [7:0] opcode_q;
	logic [ADDR_W-1:0] addr_q;
	logic [1:0] addr_cnt;
	logic last_q;
	logic launched;
	logic polling;
	logic [7:0] close_cnt;
	logic [31:0] poll_cnt;
	logic eng_start;
	logic [7:0] eng_tx;
	logic eng_busy;
	logic eng_done;
	logic [7:0] eng_rx;
	logic accept;
	logic refuse;
	logic close_end;
	logic is_program;

	////////////////////////////////////////////////////////////////////////////////
	// Opcode table, indexed by kind and buffer.
	function automatic logic [7:0] pick_opcode(input cmd_kind_e k, input logic second);
		logic [7:0] op;
		op = 8'h00;
		unique case (k)
			// R1: load opcodes
			CMD_LOAD: op = second ? OP_LOAD_BUF2 : OP_LOAD_BUF1;
			// R6: erase program opcodes
			CMD_PROG_ERASE: op = second ? OP_PROG_ERASE_BUF2 : OP_PROG_ERASE_BUF1;
			// R12: no-erase opcodes
			CMD_PROG_NOERASE: op = second ? OP_PROG_NOERASE_BUF2 : OP_PROG_NOERASE_BUF1;
			// R15: combined opcodes
			CMD_LOAD_PROG: op = second ? OP_LOAD_PROG_BUF2 : OP_LOAD_PROG_BUF1;
		endcase
		return op;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Address layout; the mode input must match the page size set in the device.
	// R19: layout by page size
	function automatic logic [ADDR_W-1:0] build_addr(input cmd_kind_e k, input logic bin,
		input logic [PAGE_W-1:0] page, input logic [INDEX_STD_W-1:0] idx);
		logic [ADDR_W-1:0] a;
		a = '0;
		unique case (k)
			CMD_LOAD: begin
				// R2: standard load address
				// R3: binary load address
				a = bin ? {16'h0000, idx[INDEX_BIN_W-1:0]} : {15'h0000, idx};
			end
			CMD_PROG_ERASE, CMD_PROG_NOERASE: begin
				// R7: standard program address
				// R8: binary program address
				a = bin ? {1'b0, page, 8'h00} : {page, 9'h000};
			end
			CMD_LOAD_PROG: begin
				// R16: standard combined address
				// R17: binary combined address
				a = bin ? {1'b0, page, idx[INDEX_BIN_W-1:0]} : {page, idx};
			end
		endcase
		return a;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Order handshake; a no-erase program to a page not known erased is turned away.
	assign cmd_ready = (state == S_IDLE);
	// R14: require pre-erased page
	assign refuse = cmd_valid && cmd_ready && (cmd_kind == CMD_PROG_NOERASE) && !page_preerased;
	assign accept = cmd_valid && cmd_ready && !refuse;
	assign is_program = (kind_q != CMD_LOAD);
	assign close_end = (state == S_CLOSE) && (close_cnt == CS_HOLD_CYCLES + CS_HIGH_CYCLES);

	// Data bytes are taken only while the shifter is free, so the source stalls between bytes.
	assign wr_ready = (state == S_DATA) && !launched && !eng_busy;

	////////////////////////////////////////////////////////////////////////////////
	// Byte to shift and when to start it.
	always_comb begin
		eng_start = 1'b0;
		eng_tx = 8'h00;
		unique case (state)
			S_OPC: begin
				eng_start = !launched;
				eng_tx = opcode_q;
			end
			S_ADDR: begin
				eng_start = !launched;
				eng_tx = addr_q[ADDR_W-1:ADDR_W-8];
			end
			S_DATA: begin
				eng_start = wr_valid && wr_ready;
				eng_tx = wr_data;
			end
			S_STAT_OP: begin
				eng_start = !launched;
				eng_tx = STATUS_OPCODE;
			end
			S_STAT_RD: begin
				eng_start = !launched;
				eng_tx = 8'h00;
			end
			S_IDLE, S_CLOSE: begin
				eng_start = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// One byte in flight at a time.
	always_ff @(posedge clk) begin
		if (rst) begin
			launched <= 1'b0;
		end else if (eng_start) begin
			launched <= 1'b1;
		end else if (eng_done) begin
			launched <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Latched command.
	always_ff @(posedge clk) begin
		if (rst) begin
			kind_q <= CMD_LOAD;
			opcode_q <= 8'h00;
			addr_q <= '0;
			addr_cnt <= 2'h0;
			last_q <= 1'b0;
		end else begin
			if (accept) begin
				kind_q <= cmd_kind;
				opcode_q <= pick_opcode(cmd_kind, cmd_buffer);
				addr_q <= build_addr(cmd_kind, binary_mode, cmd_page, cmd_index);
				addr_cnt <= 2'h0;
				last_q <= 1'b0;
			end
			if (state == S_ADDR && eng_done) begin
				addr_q <= {addr_q[ADDR_W-9:0], 8'h00};
				addr_cnt <= addr_cnt + 2'h1;
			end
			if (eng_start && state == S_DATA) begin
				last_q <= wr_last;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame sequencer.
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= S_IDLE;
			polling <= 1'b0;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (accept) begin
						state <= S_OPC;
						polling <= 1'b0;
					end
				end
				S_OPC: begin
					if (eng_done) begin
						state <= S_ADDR;
					end
				end
				S_ADDR: begin
					if (eng_done && addr_cnt == ADDR_LAST_BYTE) begin
						state <= (kind_q == CMD_LOAD || kind_q == CMD_LOAD_PROG) ? S_DATA : S_CLOSE;
					end
				end
				S_DATA: begin
					// R4: stream consecutive bytes
					// R5: frame ends after last
					if (eng_done && last_q) begin
						state <= S_CLOSE;
					end
				end
				S_STAT_OP: begin
					if (eng_done) begin
						state <= S_STAT_RD;
					end
				end
				S_STAT_RD: begin
					if (eng_done) begin
						state <= S_CLOSE;
					end
				end
				S_CLOSE: begin
					if (close_end) begin
						if (!polling) begin
							// R9: wait erase and program
							// R13: wait plain program
							// R18: wait combined operation
							state <= is_program ? S_STAT_OP : S_IDLE;
							polling <= is_program;
						end else if (status_byte[READY_BIT] || poll_cnt >= 32'(POLL_LIMIT_CYCLES)) begin
							state <= S_IDLE;
							polling <= 1'b0;
						end else begin
							state <= S_STAT_OP;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Chip select: low for the whole frame, raised only on a byte boundary after a hold.
	always_ff @(posedge clk) begin
		if (rst) begin
			spi_cs_n <= 1'b1;
			close_cnt <= 8'h00;
		end else begin
			if (accept || (close_end && (is_program || polling) &&
				!(polling && (status_byte[READY_BIT] || poll_cnt >= 32'(POLL_LIMIT_CYCLES))))) begin
				spi_cs_n <= 1'b0;
			end else if (state == S_CLOSE && close_cnt == CS_HOLD_CYCLES) begin
				spi_cs_n <= 1'b1;
			end
			if (state == S_CLOSE && !close_end) begin
				close_cnt <= close_cnt + 8'h01;
			end else begin
				close_cnt <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Busy wait bounded by the longest operation time.
	// R10: poll until ready
	always_ff @(posedge clk) begin
		if (rst) begin
			poll_cnt <= 32'h0000_0000;
		end else if (!polling) begin
			poll_cnt <= 32'h0000_0000;
		end else if (poll_cnt != 32'hffff_ffff) begin
			poll_cnt <= poll_cnt + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status capture and result flags; the error flags clear only on reset or when a new order is taken, cmd_done and cmd_refused last one cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			status_byte <= 8'h00;
			flash_busy <= 1'b0;
			program_error <= 1'b0;
			timeout_error <= 1'b0;
			cmd_done <= 1'b0;
			cmd_refused <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			cmd_refused <= refuse;
			if (accept) begin
				program_error <= 1'b0;
				timeout_error <= 1'b0;
				status_byte <= 8'h00;
			end
			if (state == S_STAT_RD && eng_done) begin
				status_byte <= eng_rx;
			end
			if (close_end && !polling) begin
				flash_busy <= is_program;
				cmd_done <= !is_program;
			end
			if (close_end && polling) begin
				if (status_byte[READY_BIT]) begin
					flash_busy <= 1'b0;
					cmd_done <= 1'b1;
					// R11: capture error flag
					program_error <= status_byte[ERROR_BIT];
				end else if (poll_cnt >= 32'(POLL_LIMIT_CYCLES)) begin
					flash_busy <= 1'b0;
					cmd_done <= 1'b1;
					timeout_error <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial shifter with the divided serial clock.
	spi_byte_engine #(
		.HALF(SCK_HALF_CYCLES)
	) engine (
		.clk(clk),
		.rst(rst),
		.start(eng_start),
		.tx_byte(eng_tx),
		.busy(eng_busy),
		.done(eng_done),
		.rx_byte(eng_rx),
		.sck(spi_sck),
		.mosi(spi_mosi),
		.miso(spi_miso)
	);

endmodule
`default_nettype wire

//--- logic/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;

	// Command opcodes, one per buffer.
	localparam logic [7:0] OP_LOAD_BUF1 = 8'h84;
	localparam logic [7:0] OP_LOAD_BUF2 = 8'h87;
	localparam logic [7:0] OP_PROG_ERASE_BUF1 = 8'h83;
	localparam logic [7:0] OP_PROG_ERASE_BUF2 = 8'h86;
	localparam logic [7:0] OP_PROG_NOERASE_BUF1 = 8'h88;
	localparam logic [7:0] OP_PROG_NOERASE_BUF2 = 8'h89;
	localparam logic [7:0] OP_LOAD_PROG_BUF1 = 8'h82;
	localparam logic [7:0] OP_LOAD_PROG_BUF2 = 8'h85;

	// Address field layout inside the three address bytes.
	localparam int PAGE_W = 15;
	localparam int INDEX_STD_W = 9;
	localparam int INDEX_BIN_W = 8;
	localparam int ADDR_W = 24;
	localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;

	// Timing of the serial frame at the system clock.
	localparam int CLK_PERIOD_NS = 25;
	localparam int CLK_MHZ = 40;
	localparam int SCK_HALF_CYCLES = 4;
	localparam int CS_HOLD_NS = 50;
	localparam int CS_HIGH_NS = 100;
	localparam logic [7:0] CS_HOLD_CYCLES = 8'((CS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CS_HIGH_CYCLES = 8'((CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Kinds of command the user may order.
	typedef enum logic [1:0] {
		CMD_LOAD = 2'h0,
		CMD_PROG_ERASE = 2'h1,
		CMD_PROG_NOERASE = 2'h2,
		CMD_LOAD_PROG = 2'h3
	} cmd_kind_e;

endpackage
`default_nettype wire

//--- logic/spi_byte_engine.sv
`timescale 1ns/1ps
`default_nettype none
module spi_byte_engine
	import flash_host_pkg::*;
#(
	parameter int HALF = SCK_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] tx_byte,
	output logic busy,
	output logic done,
	output logic [7:0] rx_byte,
	output logic sck,
	output logic mosi,
	input wire logic miso
);

	logic [2:0] miso_sync;
	logic miso_stable;
	logic active;
	logic phase_high;
	logic [7:0] div_cnt;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;

	assign busy = active;

	////////////////////////////////////////////////////////////////////////////////
	// Three flops on the pin; a change counts only once the last two agree.
	always_ff @(posedge clk) begin
		if (rst) begin
			miso_sync <= 3'h0;
			miso_stable <= 1'b0;
		end else begin
			miso_sync <= {miso_sync[1:0], miso};
			if (miso_sync[1] == miso_sync[2]) begin
				miso_stable <= miso_sync[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode 0 shifter: the far end samples on the rising edge, so data changes with the falling one.
	// Input is taken at the end of the high phase, which leaves room for the sync latency.
	// R20: MSB first shift
	always_ff @(posedge clk) begin
		if (rst) begin
			active <= 1'b0;
			phase_high <= 1'b0;
			div_cnt <= 8'h00;
			bit_cnt <= 3'h0;
			shreg <= 8'h00;
			sck <= 1'b0;
			mosi <= 1'b0;
			done <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			done <= 1'b0;
			if (!active) begin
				if (start) begin
					active <= 1'b1;
					phase_high <= 1'b0;
					div_cnt <= 8'h00;
					bit_cnt <= 3'h7;
					shreg <= tx_byte;
					mosi <= tx_byte[7];
				end
			end else if (div_cnt == 8'(HALF - 1)) begin
				div_cnt <= 8'h00;
				if (!phase_high) begin
					sck <= 1'b1;
					phase_high <= 1'b1;
				end else begin
					sck <= 1'b0;
					phase_high <= 1'b0;
					rx_byte <= {rx_byte[6:0], miso_stable};
					if (bit_cnt == 3'h0) begin
						active <= 1'b0;
						done <= 1'b1;
					end else begin
						bit_cnt <= bit_cnt - 3'h1;
						shreg <= {shreg[6:0], 1'b0};
						mosi <= shreg[6];
					end
				end
			end else begin
				div_cnt <= div_cnt + 8'h01;
			end
		end
	end

endmodule
`default_nettype wire

//--- tb/flash_buffer_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
module flash_buffer_host_properties
	import flash_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire cmd_kind_e cmd_kind,
	input wire logic page_preerased,
	input wire logic cmd_refused,
	input wire logic cmd_done,
	input wire logic flash_busy,
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_mosi
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// An order that lacks the erase guarantee must never reach the wire.
	logic take;
	logic gate;
	assign take = cmd_valid && cmd_ready;
	assign gate = cmd_kind == CMD_PROG_NOERASE && !page_preerased;
	sequence s_sck_high; spi_sck [*4] ##1 !spi_sck; endsequence
	sequence s_cs_gap; spi_cs_n [*4]; endsequence
	property p_refuse; take && gate |=> (cmd_refused && spi_cs_n) ##1 spi_cs_n; endproperty
	property p_start; take && !gate |-> ##[1:3] !spi_cs_n; endproperty
	property p_idle_cs; cmd_ready |-> spi_cs_n; endproperty
	property p_sck_idle; spi_cs_n |-> !spi_sck; endproperty
	property p_sck_half; $rose(spi_sck) |-> s_sck_high; endproperty
	property p_mosi_hold; spi_sck |-> $stable(spi_mosi); endproperty
	property p_busy_block; flash_busy |-> !cmd_ready; endproperty
	property p_done_ready; cmd_done |-> spi_cs_n && cmd_ready; endproperty
	property p_cs_gap; $rose(spi_cs_n) |-> s_cs_gap; endproperty
	a_refuse: assert property (p_refuse) else $error("refused order reached the wire");
	a_start: assert property (p_start) else $error("accepted order opened no frame");
	a_idle_cs: assert property (p_idle_cs) else $error("select low while idle");
	a_sck_idle: assert property (p_sck_idle) else $error("serial clock not idle low");
	a_sck_half: assert property (p_sck_half) else $error("clock high phase wrong");
	a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
	a_busy_block: assert property (p_busy_block) else $error("ready while device busy");
	a_done_ready: assert property (p_done_ready) else $error("done without closed frame");
	a_cs_gap: assert property (p_cs_gap) else $error("select high time too short");
endmodule
bind flash_buffer_host flash_buffer_host_properties i_flash_buffer_host_properties (.clk, .rst, .cmd_valid,
	.cmd_ready, .cmd_kind, .page_preerased, .cmd_refused, .cmd_done, .flash_busy, .spi_cs_n, .spi_sck, .spi_mosi);
`default_nettype wire

//--- tb/flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
	parameter logic [7:0] STATUS_OP = 8'h57,
	parameter int BUSY_POLLS = 2
) (
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	output logic spi_miso,
	input wire logic binary_mode,
	input wire logic stuck_busy
);
	logic [7:0] buf_mem [2][264];
	logic [7:0] page_mem [int];
	logic [7:0] last_op, sr, tx, old;
	logic [23:0] last_addr;
	logic miso_q, erase_program_error_flag, stat, sel;
	int nbits, nbytes, ptr, polls, base, size;
	assign size = binary_mode ? 256 : 264;
	assign sel = last_op inside {8'h87, 8'h86, 8'h89, 8'h85};
	// A released line shows the inverse, so a stale bit is never read as good.
	assign spi_miso = spi_cs_n ? ~miso_q : miso_q;
	initial begin
		foreach (buf_mem[b, i]) buf_mem[b][i] = 8'hff;
		{miso_q, erase_program_error_flag, stat, last_op, tx} = '0;
		polls = 0;
		nbytes = 0;
	end
	always @(negedge spi_cs_n) begin
		nbits = 0;
		nbytes = 0;
	end
	always @(posedge spi_sck) if (!spi_cs_n) begin
		sr = {sr[6:0], spi_mosi};
		nbits++;
		if (nbits % 8 == 0) begin
			if (nbytes == 0) begin
				stat = sr == STATUS_OP;
				tx = {polls == 0 && !stuck_busy, 1'b0, erase_program_error_flag, 5'h0};
				if (!stat) last_op = sr;
			end else if (!stat && nbytes < 4) begin
				last_addr = {last_addr[15:0], sr};
				ptr = binary_mode ? int'(last_addr[7:0]) : int'(last_addr[8:0]);
			end else if (!stat && last_op inside {8'h84, 8'h87, 8'h82, 8'h85}) begin
				buf_mem[sel][ptr] = sr;
				ptr = (ptr + 1) % size;
			end
			nbytes++;
		end
	end
	// Status leaves on the falling edge, ahead of the host's sample.
	always @(negedge spi_sck) if (!spi_cs_n) begin
		miso_q = tx[7];
		tx = {tx[6:0], ~tx[7]};
	end
	always @(posedge spi_cs_n) begin
		if (stat && polls > 0) polls--;
		else if (!stat && nbytes >= 4 && !(last_op inside {8'h84, 8'h87})) begin
			base = (binary_mode ? int'(last_addr[22:8]) : int'(last_addr[23:9])) * 512;
			erase_program_error_flag = 1'b0;
			polls = BUSY_POLLS;
			for (int i = 0; i < size; i++) begin
				old = (last_op inside {8'h88, 8'h89} && page_mem.exists(base + i)) ? page_mem[base + i] : 8'hff;
				page_mem[base + i] = old & buf_mem[sel][i];
				if ((old & buf_mem[sel][i]) !== buf_mem[sel][i]) erase_program_error_flag = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/flash_buffer_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module flash_buffer_host_tb;
	import flash_host_pkg::*;
	typedef struct {cmd_kind_e kind; logic b; logic bin; logic [14:0] page; logic [8:0] idx; int n; logic pre;
		logic err;} row_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0, cmd_buffer = 1'b0, binary_mode = 1'b0, page_preerased = 1'b0;
	logic wr_valid = 1'b0, wr_last = 1'b0, stuck_busy = 1'b0;
	cmd_kind_e cmd_kind = CMD_LOAD;
	logic [14:0] cmd_page = 15'h0;
	logic [8:0] cmd_index = 9'h0;
	logic [7:0] wr_data = 8'h0;
	logic cmd_ready, cmd_refused, wr_ready, cmd_done, flash_busy, program_error, timeout_error;
	logic spi_cs_n, spi_sck, spi_mosi, spi_miso;
	logic [7:0] status_byte;
	logic [7:0] exp_buf [2][264];
	logic [7:0] opc [8] = '{8'h84, 8'h87, 8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85};
	int num_errors = 0, cmp_count = 0, cycles = 0;
	// Wrap rows start near the buffer end; the last row programs a dirty page.
	row_s rows [8] = '{
		'{CMD_LOAD, 1'b0, 1'b0, 15'h0, 9'h106, 3, 1'b0, 1'b0},
		'{CMD_PROG_ERASE, 1'b0, 1'b0, 15'h1234, 9'h0, 0, 1'b0, 1'b0},
		'{CMD_LOAD, 1'b1, 1'b1, 15'h0, 9'h0fe, 3, 1'b0, 1'b0},
		'{CMD_PROG_NOERASE, 1'b1, 1'b1, 15'h42, 9'h0, 0, 1'b1, 1'b0},
		'{CMD_PROG_ERASE, 1'b1, 1'b1, 15'h7fff, 9'h0, 0, 1'b0, 1'b0},
		'{CMD_LOAD_PROG, 1'b0, 1'b0, 15'h1, 9'h0, 2, 1'b0, 1'b0},
		'{CMD_LOAD_PROG, 1'b1, 1'b1, 15'h2aaa, 9'h010, 2, 1'b0, 1'b0},
		'{CMD_PROG_NOERASE, 1'b0, 1'b0, 15'h1234, 9'h0, 0, 1'b1, 1'b1}};
	flash_buffer_host #(.STATUS_OPCODE(8'h57), .POLL_LIMIT_CYCLES(3000)) i_flash_buffer_host (.clk, .rst,
		.cmd_valid, .cmd_ready, .cmd_kind, .cmd_buffer, .binary_mode, .cmd_page, .cmd_index, .page_preerased,
		.cmd_refused, .wr_valid, .wr_ready, .wr_data, .wr_last, .cmd_done, .flash_busy, .program_error,
		.timeout_error, .status_byte, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso);
	flash_model #(.STATUS_OP(8'h57), .BUSY_POLLS(2)) i_flash_model (.spi_cs_n, .spi_sck, .spi_mosi, .spi_miso,
		.binary_mode, .stuck_busy);
	always #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	// Inputs move on the falling edge, so the rising edge sees them settled.
	task automatic issue(input row_s r);
		cmd_valid = 1'b1;
		cmd_kind = r.kind;
		cmd_buffer = r.b;
		binary_mode = r.bin;
		cmd_page = r.page;
		cmd_index = r.idx;
		page_preerased = r.pre;
		while (!cmd_ready) @(negedge clk);
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask
	task automatic run(input row_s r, input int tag);
		int t;
		int size;
		logic seen;
		logic [8:0] at;
		logic [8:0] first;
		logic [23:0] adr;
		size = r.bin ? 256 : 264;
		at = r.bin ? {1'b0, r.idx[7:0]} : r.idx;
		first = at;
		adr = r.kind == CMD_LOAD ? {15'h0, at} : {r.bin ? {1'b0, r.page} : {r.page, 1'b0},
			r.kind == CMD_LOAD_PROG ? r.idx[7:0] : 8'h0};
		if (r.kind == CMD_LOAD_PROG && !r.bin) adr[8] = r.idx[8];
		issue(r);
		for (int k = 0; k < r.n; k++) begin
			wr_valid = 1'b1;
			wr_data = {4'(tag), 4'(k)};
			wr_last = k == r.n - 1;
			while (!wr_ready) @(negedge clk);
			exp_buf[r.b][at] = wr_data;
			at = 9'((at + 1) % size);
			@(negedge clk);
		end
		{wr_valid, wr_last, seen} = 3'h0;
		t = 0;
		while (!cmd_done && t < 4000) begin
			seen |= flash_busy;
			t++;
			@(negedge clk);
		end
		`CHK("done", 1'b1, cmd_done)
		`CHK("opcode", opc[{r.kind, r.b}], i_flash_model.last_op)
		`CHK("address", adr, i_flash_model.last_addr)
		`CHK("busy seen", r.kind != CMD_LOAD, seen)
		`CHK("error flag", r.err, program_error)
		`CHK("status", r.kind == CMD_LOAD ? 8'h00 : {!stuck_busy, 1'b0, r.err, 5'h00}, status_byte)
		`CHK("buffer first", exp_buf[r.b][first], i_flash_model.buf_mem[r.b][first])
		`CHK("buffer wrap", exp_buf[r.b][0], i_flash_model.buf_mem[r.b][0])
		if (r.kind != CMD_LOAD && !r.err)
			`CHK("page", exp_buf[r.b][first], i_flash_model.page_mem[int'(r.page) * 512 + int'(first)])
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		int lows;
		foreach (exp_buf[b, i]) exp_buf[b][i] = 8'hff;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		`CHK("ready after reset", 1'b1, cmd_ready)
		`CHK("select after reset", 1'b1, spi_cs_n)
		for (int r = 0; r < 8; r++) begin
			run(rows[r], r);
			$display("test %0d done", r);
		end
		issue('{CMD_PROG_NOERASE, 1'b0, 1'b0, 15'h5, 9'h0, 0, 1'b0, 1'b0});
		`CHK("refused", 1'b1, cmd_refused)
		lows = 0;
		repeat (80) @(negedge clk) lows += !spi_cs_n;
		`CHK("no frame sent", 0, lows)
		$display("test refusal done");
		stuck_busy = 1'b1;
		run('{CMD_PROG_ERASE, 1'b0, 1'b0, 15'h3, 9'h0, 0, 1'b0, 1'b0}, 9);
		`CHK("timeout flag", 1'b1, timeout_error)
		stuck_busy = 1'b0;
		$display("test timeout done");
		issue('{CMD_LOAD, 1'b1, 1'b0, 15'h0, 9'h0, 0, 1'b0, 1'b0});
		repeat (100) @(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("select in reset", 1'b1, spi_cs_n)
		`CHK("ready in reset", 1'b1, cmd_ready)
		`CHK("flag in reset", 1'b0, timeout_error)
		rst = 1'b0;
		`CHK("ready after release", 1'b1, cmd_ready)
		// A fresh load after the cut frame shows the controller and the far end both recovered.
		run('{CMD_LOAD, 1'b0, 1'b0, 15'h0, 9'h005, 1, 1'b0, 1'b0}, 10);
		$display("test reset done");
		close_out();
	end
endmodule
`default_nettype wire
